// File: rtl/ivt_defines.svh
// constants for the input-voltage telemetry select block
`ifndef IVT_DEFINES_SVH
`define IVT_DEFINES_SVH
// ==========================================
// source selector codes
`define IVT_SEL_RECT0_INIT 3'h0
`define IVT_SEL_RECT1_INIT 3'h1
`define IVT_SEL_CHAIN 3'h2
`define IVT_SEL_TLM_ADC 3'h3
`define IVT_SEL_FORCE 3'h4
`define IVT_SEL_RECT0_ZERO 3'h5
`define IVT_SEL_PRIM0 3'h6
`define IVT_SEL_PRIM1 3'h7
// ==========================================
// reset values
`define IVT_SEL_RESET 3'h0
// ==========================================
// field positions: slope has this many fraction bits (slope = 1.2 * 2^5 / ratio)
`define IVT_SLOPE_FRAC 5
// alpha is a 6-bit weight, full scale 64
`define IVT_ALPHA_SHIFT 6
`endif

// File: rtl/ivt_pkg.sv
// types shared by the input-voltage telemetry select block
package ivt_pkg;
   // ==========================================
   // per-loop source selector
   typedef logic [2:0] ivt_sel_t;
   // sequencing of the current estimator
   typedef enum logic [1:0] {ivt_idle, ivt_mul, ivt_div} ivt_est_e;
endpackage

// File: rtl/ivt_iin_est.sv
// input-current estimator from vin, vout, iout and duty
`timescale 1ns/1ps
module ivt_iin_est
   import ivt_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic [W-1:0] vin,
   input wire logic [W-1:0] vout,
   input wire logic [W-1:0] iout,
   input wire logic [W-1:0] duty,
   input wire logic [5:0] alpha,
   output logic [W-1:0] iin,
   output logic done
);
`include "ivt_defines.svh"
   // ==========================================
   // state
   ivt_est_e state_ff; // sequencer
   logic [2*W-1:0] num_ff; // dividend vout*iout
   logic [2*W-1:0] rem_ff; // restoring-division remainder
   logic [W-1:0] quo_ff; // ratio vout*iout/vin
   logic [W-1:0] vin_ff; // divisor latched at start
   logic [5:0] cnt_ff; // division step count
   logic [2*W+6:0] mix; // weighted blend
   logic [2*W:0] trial; // trial subtraction
   logic [2*W-1:0] dprod; // duty times iout
   // ==========================================
   // one quotient bit per clock keeps the divider small at 250 MHz
   assign trial = {1'b0, rem_ff[2*W-2:0], num_ff[2*W-1]} - {1'b0, {W{1'b0}}, vin_ff};
   // operands widened first so the product keeps all its bits
   assign dprod = {{W{1'b0}}, duty} * {{W{1'b0}}, iout};
   // blend: iin = (alpha*ratio_path + (64-alpha)*duty_path) / 64
   assign mix = ({7'h00, {W{1'b0}}, quo_ff} * {{(2*W+1){1'b0}}, alpha})
      + ({7'h00, dprod >> W} * {{(2*W){1'b0}}, 7'h40 - {1'b0, alpha}});
   // ==========================================
   // sequencer and datapath
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_ff <= ivt_idle;
         num_ff <= '0;
         rem_ff <= '0;
         quo_ff <= '0;
         vin_ff <= '0;
         cnt_ff <= 6'h00;
         iin <= '0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_ff)
            ivt_idle: begin
               if (start) begin
                  num_ff <= {{W{1'b0}}, vout} * {{W{1'b0}}, iout};
                  vin_ff <= vin;
                  rem_ff <= '0;
                  quo_ff <= '0;
                  state_ff <= ivt_mul;
               end
            end
            ivt_mul: begin
               // a zero vin would divide by zero: report zero instead
               cnt_ff <= 6'(2*W);
               state_ff <= (vin_ff == '0) ? ivt_idle : ivt_div;
               if (vin_ff == '0) begin
                  iin <= '0;
                  done <= 1'b1;
               end
            end
            ivt_div: begin
               num_ff <= {num_ff[2*W-2:0], 1'b0};
               if (!trial[2*W]) begin
                  rem_ff <= trial[2*W-1:0];
                  quo_ff <= {quo_ff[W-2:0], 1'b1};
               end else begin
                  rem_ff <= {rem_ff[2*W-2:0], num_ff[2*W-1]};
                  quo_ff <= {quo_ff[W-2:0], 1'b0};
               end
               cnt_ff <= cnt_ff - 6'h01;
               if (cnt_ff == 6'h01) begin
                  state_ff <= ivt_idle;
               end
            end
            default: state_ff <= ivt_idle;
         endcase
         // publish result the cycle after the last quotient bit
         if (state_ff == ivt_div && cnt_ff == 6'h01) begin
            done <= 1'b1;
         end
         if (done && vin_ff != '0) begin
            iin <= W'(mix >> `IVT_ALPHA_SHIFT);
         end
      end
   end
endmodule // ivt_iin_est

// File: rtl/ivt_top.sv
// input-voltage telemetry source select with adc scaling and input-current estimate
// ==========================================
// Summary of operation
// RULE1 - selector 2: loop 0 vout feeds loop 1
// RULE2 - selector 3: vin from telemetry converter
// RULE3 - selector 4: firmware forced vin
// RULE4 - 0,1,5 rectified sense; 6,7 primary sense
// RULE5 - adc vin equals slope times code plus trim
// RULE6 - software sets slope 1.2*32/divider ratio
// RULE7 - software sets rectified initial value, full bridge
// RULE8 - half bridge initial value uses half vin
// RULE9 - estimate input current, alpha weights ratio/duty
// RULE10 - separate three-bit selector per loop, reset zero
`timescale 1ns/1ps
module ivt_top
   import ivt_pkg::*;
#(
   parameter int W = 16, // telemetry word width
   parameter int AW = 12 // telemetry converter code width
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [2:0] loop0_input_voltage_source_selector,
   input wire logic [2:0] loop1_input_voltage_source_selector,
   input wire logic [W-1:0] rectified_voltage_sense_input,
   input wire logic [W-1:0] second_rectified_sense_input,
   input wire logic [W-1:0] loop0_output_voltage,
   input wire logic [W-1:0] loop1_output_voltage,
   input wire logic [AW-1:0] telemetry_converter_code,
   input wire logic telemetry_converter_valid,
   input wire logic [W-1:0] vin_slope,
   input wire logic [W-1:0] vin_trim,
   input wire logic [W-1:0] vin_force,
   input wire logic [W-1:0] rect_init_value,
   input wire logic [1:0] loop_started,
   input wire logic [1:0] iin_estimate_enable,
   input wire logic [W-1:0] loop0_output_current,
   input wire logic [W-1:0] loop1_output_current,
   input wire logic [W-1:0] loop0_duty,
   input wire logic [W-1:0] loop1_duty,
   input wire logic [5:0] iin_alpha,
   output logic [W-1:0] loop0_input_voltage,
   output logic [W-1:0] loop1_input_voltage,
   output logic [W-1:0] loop0_input_current,
   output logic [W-1:0] loop1_input_current,
   output logic [1:0] iin_update
);
`include "ivt_defines.svh"
   // ==========================================
   // loop start inputs pass two flops before use; selectors pass one
   logic [1:0] started_s1_ff; // first synchroniser stage
   logic [1:0] started_s2_ff; // synchronised start flags
   ivt_sel_t sel_ff [2]; // per-loop selectors registered
   logic [W-1:0] adc_vin_ff; // scaled converter result
   logic [W-1:0] vout [2]; // per-loop measured vout
   logic [W-1:0] iout [2]; // per-loop output current
   logic [W-1:0] duty [2]; // per-loop duty
   logic [W-1:0] vin_q [2]; // per-loop selected vin
   logic [W-1:0] iin_q [2]; // estimator results
   logic [1:0] est_done; // estimator done pulses
   logic [7:0] tick_ff; // estimator launch divider
   logic [W+AW-1:0] adc_prod; // slope times code
   logic [W-1:0] adc_sum; // scaled plus trim

   assign vout[0] = loop0_output_voltage;
   assign vout[1] = loop1_output_voltage;
   assign iout[0] = loop0_output_current;
   assign iout[1] = loop1_output_current;
   assign duty[0] = loop0_duty;
   assign duty[1] = loop1_duty;

   // ==========================================
   // start flags come from other logic domains, so synchronise
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         started_s1_ff <= 2'h0;
         started_s2_ff <= 2'h0;
      end else begin
         started_s1_ff <= loop_started;
         started_s2_ff <= started_s1_ff;
      end
   end

   // ==========================================
   // selectors, one per loop, reset to zero
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sel_ff[0] <= `IVT_SEL_RESET; // [RULE10]
         sel_ff[1] <= `IVT_SEL_RESET; // [RULE10]
      end else begin
         sel_ff[0] <= loop0_input_voltage_source_selector;
         sel_ff[1] <= loop1_input_voltage_source_selector;
      end
   end

   // ==========================================
   // converter scaling: slope carries 5 fraction bits; the sum wraps, so trim must keep it in range
   assign adc_prod = {{AW{1'b0}}, vin_slope} * {{W{1'b0}}, telemetry_converter_code};
   assign adc_sum = W'(adc_prod >> `IVT_SLOPE_FRAC) + vin_trim;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         adc_vin_ff <= '0;
      end else if (telemetry_converter_valid) begin
         adc_vin_ff <= adc_sum; // [RULE5]
      end
   end

   // ==========================================
   // per-loop source mux and current estimator
   for (genvar g = 0; g < 2; g++) begin : g_loop
      logic [W-1:0] rect; // rectified source for this loop
      logic [W-1:0] nxt_vin; // next selected vin
      logic [W-1:0] vin_ff; // registered vin output
      assign rect = (g == 0) ? rectified_voltage_sense_input : second_rectified_sense_input;
      // source choice; the rectified init value is loaded by software
      always_comb begin
         case (sel_ff[g])
            `IVT_SEL_RECT0_INIT: nxt_vin = started_s2_ff[g] ? rectified_voltage_sense_input
               : rect_init_value; // [RULE4]
            `IVT_SEL_RECT1_INIT: nxt_vin = started_s2_ff[g] ? second_rectified_sense_input
               : rect_init_value; // [RULE4]
            `IVT_SEL_CHAIN: nxt_vin = (g == 1) ? loop0_output_voltage : rect; // [RULE1]
            `IVT_SEL_TLM_ADC: nxt_vin = adc_vin_ff; // [RULE2]
            `IVT_SEL_FORCE: nxt_vin = vin_force; // [RULE3]
            `IVT_SEL_RECT0_ZERO: nxt_vin = started_s2_ff[g] ? rectified_voltage_sense_input
               : '0; // [RULE4]
            `IVT_SEL_PRIM0: nxt_vin = rectified_voltage_sense_input; // [RULE4]
            `IVT_SEL_PRIM1: nxt_vin = second_rectified_sense_input; // [RULE4]
            default: nxt_vin = '0;
         endcase
      end
      // registered so the data output comes from a flop
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            vin_ff <= '0;
         end else begin
            vin_ff <= nxt_vin;
         end
      end
      assign vin_q[g] = vin_ff;
      // estimator launched on a periodic tick while enabled
      ivt_iin_est #(.W(W)) u_est (
         .clock(clock),
         .reset(reset),
         .start(iin_estimate_enable[g] && tick_ff == 8'h00), // [RULE9]
         .vin(vin_ff),
         .vout(vout[g]),
         .iout(iout[g]),
         .duty(duty[g]),
         .alpha(iin_alpha),
         .iin(iin_q[g]),
         .done(est_done[g])
      );
   end

   // ==========================================
   // free-running launch divider; 256 cycles exceeds one estimate (~35 cycles)
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tick_ff <= 8'h00;
      end else begin
         tick_ff <= tick_ff + 8'h01;
      end
   end

   assign loop0_input_voltage = vin_q[0];
   assign loop1_input_voltage = vin_q[1];
   assign loop0_input_current = iin_q[0];
   assign loop1_input_current = iin_q[1];
   assign iin_update = est_done;
endmodule // ivt_top

// File: bench/ivt_top_sva.sv
// concurrent checks on the ports of the input-voltage telemetry select block
`timescale 1ns/1ps
`include "ivt_defines.svh"
module ivt_top_chk
   import ivt_pkg::*;
#(
   parameter int W = 16,
   parameter int AW = 12
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [2:0] loop0_input_voltage_source_selector,
   input wire logic [2:0] loop1_input_voltage_source_selector,
   input wire logic [W-1:0] rectified_voltage_sense_input,
   input wire logic [W-1:0] second_rectified_sense_input,
   input wire logic [W-1:0] loop0_output_voltage,
   input wire logic [AW-1:0] telemetry_converter_code,
   input wire logic telemetry_converter_valid,
   input wire logic [W-1:0] vin_slope,
   input wire logic [W-1:0] vin_trim,
   input wire logic [W-1:0] vin_force,
   input wire logic [W-1:0] rect_init_value,
   input wire logic [1:0] loop_started,
   input wire logic [W-1:0] loop0_input_voltage,
   input wire logic [W-1:0] loop1_input_voltage,
   input wire logic [1:0] iin_update
);
   // ==========================================
   // expected converter result, latched on each valid pulse; wide product so no bits drop before the shift
   logic [W-1:0] adc_exp_ff;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         adc_exp_ff <= '0;
      end else if (telemetry_converter_valid) begin
         adc_exp_ff <= W'(((W+AW)'(vin_slope) * (W+AW)'(telemetry_converter_code)) >> `IVT_SLOPE_FRAC) + vin_trim;
      end
   end
   // ==========================================
   // checks, all in the one clock domain
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_force_select: assert property (
      (loop0_input_voltage_source_selector == 3'h4 && $stable(vin_force))[*2] |=> loop0_input_voltage == $past(vin_force))
      else $error("loop0 input voltage does not follow the forced value");
   a_chain_select: assert property (
      (loop1_input_voltage_source_selector == 3'h2 && $stable(loop0_output_voltage))[*2]
      |=> loop1_input_voltage == $past(loop0_output_voltage)) else $error("loop1 input voltage not taken from loop0 output");
   a_adc_scaled_value: assert property (
      telemetry_converter_valid && loop0_input_voltage_source_selector == 3'h3 ##1
      (loop0_input_voltage_source_selector == 3'h3 && !telemetry_converter_valid) |=> loop0_input_voltage == adc_exp_ff)
      else $error("converter input voltage is not slope times code plus trim");
   a_rect_init_hold: assert property (
      (loop0_input_voltage_source_selector == 3'h0 && !loop_started[0] && $stable(rect_init_value))[*4]
      |=> loop0_input_voltage == $past(rect_init_value)) else $error("initial value not shown before start");
   a_rect_after_start: assert property (
      (loop0_input_voltage_source_selector == 3'h0 && loop_started[0] && $stable(rectified_voltage_sense_input))[*4]
      |=> loop0_input_voltage == $past(rectified_voltage_sense_input)) else $error("rectified sense not used after start");
   a_zero_prestart: assert property (
      (loop0_input_voltage_source_selector == 3'h5 && !loop_started[0])[*4] |=> loop0_input_voltage == '0)
      else $error("selector five does not report zero before start");
   a_raw_primary_six: assert property (
      (loop0_input_voltage_source_selector == 3'h6 && $stable(rectified_voltage_sense_input))[*2]
      |=> loop0_input_voltage == $past(rectified_voltage_sense_input)) else $error("selector six does not pass raw sense");
   a_raw_primary_seven: assert property (
      (loop1_input_voltage_source_selector == 3'h7 && $stable(second_rectified_sense_input))[*2]
      |=> loop1_input_voltage == $past(second_rectified_sense_input)) else $error("selector seven does not pass raw sense");
   a_update_pulse: assert property (iin_update[0] |=> !iin_update[0])
      else $error("current update strobe longer than one cycle");
endmodule // ivt_top_chk
bind ivt_top ivt_top_chk #(.W(W), .AW(AW)) ivt_top_chk_i (.clock(clock), .reset(reset),
   .loop0_input_voltage_source_selector(loop0_input_voltage_source_selector),
   .loop1_input_voltage_source_selector(loop1_input_voltage_source_selector),
   .rectified_voltage_sense_input(rectified_voltage_sense_input), .second_rectified_sense_input(second_rectified_sense_input),
   .loop0_output_voltage(loop0_output_voltage), .telemetry_converter_code(telemetry_converter_code),
   .telemetry_converter_valid(telemetry_converter_valid), .vin_slope(vin_slope), .vin_trim(vin_trim), .vin_force(vin_force),
   .rect_init_value(rect_init_value), .loop_started(loop_started), .loop0_input_voltage(loop0_input_voltage),
   .loop1_input_voltage(loop1_input_voltage), .iin_update(iin_update));

// File: bench/testbench.sv
// self-checking bench for the input-voltage telemetry select block
`timescale 1ns/1ps
module testbench
   import ivt_pkg::*;
;
   // ==========================================
   // one table row: selectors and start state beside the voltages they should give
   typedef struct {ivt_sel_t s0; ivt_sel_t s1; logic [1:0] st; logic [15:0] e0; logic [15:0] e1;} ivt_row_s;
   ivt_row_s rows [8] = '{'{3'h4, 3'h2, 2'h0, 16'h03E8, 16'h0064}, '{3'h0, 3'h1, 2'h0, 16'h003A, 16'h003A},
      '{3'h0, 3'h1, 2'h3, 16'h1234, 16'h2345}, '{3'h5, 3'h5, 2'h0, 16'h0000, 16'h0000},
      '{3'h5, 3'h5, 2'h3, 16'h1234, 16'h1234}, '{3'h6, 3'h7, 2'h0, 16'h1234, 16'h2345},
      '{3'h1, 3'h0, 2'h3, 16'h2345, 16'h1234}, '{3'h2, 3'h6, 2'h3, 16'h1234, 16'h1234}};
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [2:0] sel0 = 3'h0, sel1 = 3'h0;
   logic [15:0] rect = 16'h1234, rect2 = 16'h2345, vout0 = 16'h0064, vout1 = 16'h000A, iout0 = 16'h0032;
   logic [15:0] iout1 = 16'h0014, duty0 = 16'h8000, duty1 = 16'h4000, trim = 16'h0005;
   logic [15:0] slope = 16'h0BB8; // 1.2*32 over a 0.0128 divider
   logic [15:0] init_v = 16'h003A; // full bridge, 48 V initial input
   logic [15:0] force_v = 16'h03E8, code_exp;
   logic [11:0] code = 12'h000;
   logic valid = 1'b0;
   logic [1:0] started = 2'h0, en = 2'h0, upd;
   logic [5:0] alpha = 6'h20;
   logic [15:0] vin0, vin1, iin0, iin1;
   int num_errors = 0, n_checks = 0;
   int codes [3] = '{0, 256, 341};
   int alphas [3] = '{63, 0, 32};
   ivt_top ivt_top_i (.clock(clock), .reset(reset), .loop0_input_voltage_source_selector(sel0),
      .loop1_input_voltage_source_selector(sel1), .rectified_voltage_sense_input(rect), .second_rectified_sense_input(rect2),
      .loop0_output_voltage(vout0), .loop1_output_voltage(vout1), .telemetry_converter_code(code),
      .telemetry_converter_valid(valid), .vin_slope(slope), .vin_trim(trim), .vin_force(force_v), .rect_init_value(init_v),
      .loop_started(started), .iin_estimate_enable(en), .loop0_output_current(iout0), .loop1_output_current(iout1),
      .loop0_duty(duty0), .loop1_duty(duty1), .iin_alpha(alpha), .loop0_input_voltage(vin0), .loop1_input_voltage(vin1),
      .loop0_input_current(iin0), .loop1_input_current(iin1), .iin_update(upd));
   // ==========================================
   // shared helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // bounded wait for one loop's update strobe; a missed strobe shows up as a failed compare
   task automatic wait_upd(input int i);
      int k;
      k = 0;
      while (upd[i] !== 1'b1 && k < 700) begin
         @(negedge clock);
         k++;
      end
      chk({15'h0, upd[i]}, 16'h0001);
      @(negedge clock);
   endtask
   // estimate worked out here from the weighting, integer division first as the hardware does
   function automatic int est(input int a, input int vin, input int vo, input int io, input int d);
      return (a * (vo * io / vin) + (64 - a) * ((d * io) >> 16)) >> 6;
   endfunction
   // ==========================================
   // clock, 4 ns period
   initial begin
      forever #2 clock = ~clock;
   end
   // watchdog well beyond the expected run of a few thousand cycles
   initial begin
      #80000;
      num_errors++;
      print_verdict();
   end
   // ==========================================
   // main sequence, inputs change on the falling edge
   initial begin
      repeat (4) @(negedge clock);
      chk(vin0 | vin1 | iin0 | iin1, 16'h0000);
      reset = 1'b0;
      // ordinary selector cases from the table
      foreach (rows[r]) begin
         sel0 = rows[r].s0;
         sel1 = rows[r].s1;
         started = rows[r].st;
         repeat (5) @(negedge clock);
         chk(vin0, rows[r].e0);
         chk(vin1, rows[r].e1);
      end
      // converter scaling on both loops, zero and two non-zero codes (256, 341) included
      sel0 = 3'h3;
      sel1 = 3'h3;
      foreach (codes[j]) begin
         code = 12'(codes[j]);
         valid = 1'b1;
         @(negedge clock);
         valid = 1'b0;
         repeat (3) @(negedge clock);
         code_exp = 16'((3000 * codes[j]) >> 5) + trim;
         chk(vin0, code_exp);
         chk(vin1, code_exp);
      end
      // current estimate at high, zero and middle weights; stale estimates flushed by two strobes
      sel0 = 3'h4;
      sel1 = 3'h2;
      en = 2'h3;
      foreach (alphas[j]) begin
         alpha = 6'(alphas[j]);
         wait_upd(0);
         wait_upd(0);
         chk(iin0, 16'(est(alphas[j], 1000, 100, 50, 32768)));
         wait_upd(1);
         chk(iin1, 16'(est(alphas[j], 100, 10, 20, 16384)));
      end
      // zero input voltage must give a zero estimate, not a divide fault
      force_v = 16'h0000;
      wait_upd(0);
      wait_upd(0);
      chk(iin0, 16'h0000);
      // half-bridge initial value (half of the 48 V input) shown before start
      sel0 = 3'h0;
      started = 2'h0;
      init_v = 16'h001D;
      repeat (5) @(negedge clock);
      chk(vin0, 16'h001D);
      sel0 = 3'h4;
      force_v = 16'h03E8;
      // second reset in mid-run clears every output
      @(negedge clock);
      reset = 1'b1;
      repeat (2) @(negedge clock);
      chk(vin0 | vin1 | iin0 | iin1, 16'h0000);
      reset = 1'b0;
      repeat (4) @(negedge clock);
      chk(vin0, 16'h03E8);
      chk(vin1, 16'h0064);
      print_verdict();
   end
endmodule // testbench
